// [inc/itm_pkg.sv]
// types and constants for the integer issue timing model
// Operation
// - data ops see three operand forms: no shift, constant shift, register shift
// - moves take 1 cycle, or 2 when shifted by a register
// - logic/arith/compare ops take 1, 2 or 3 cycles by shift form
// - saturating and halving parallel add/sub take 2 cycles, unshifted only
// - doubling saturating add/sub and word saturate take 3 cycles
// - dual-halfword saturate and plain parallel add/sub take 1 cycle
// - extend-and-add ops take 3 cycles
// - plain extend ops take 2 cycles
// - bitfield clear, insert and extract take 2 cycles
// - count zeros, half moves, reverses and status reads take 1 cycle
// - status writes not touching mode or control take 1 cycle, not serializing
// - load forwarding path saves exactly one cycle of load-use penalty
// - forwarding only for unshifted arith/logic/saturate after plain unconditional load
// - load latency counts to the first loaded register
// - simple word loads: 1 address cycle, latency 2 forwarded, 3 otherwise
// - register-shifted word loads: 1 address cycle, latency 3 or 4
// - simple byte/halfword loads: 2 address cycles, latency 3 or 4
// - register-shifted byte/halfword loads: 2 address cycles, latency 4 or 5
// - two words per beat, but a 64-bit beat needs a 64-bit aligned address
// - multi-register transfers take cycles set by list length and alignment
package itm_pkg;
    localparam int ITM_NUM_REGS = 16;
    localparam int ITM_SB_W = 3;
    localparam int ITM_AGU_W = 4;

    localparam logic [1:0] CYC_BASE = 2'h1;
    localparam logic [1:0] CYC_MOV_REG = 2'h2;
    localparam logic [1:0] CYC_ALU_CONST = 2'h2;
    localparam logic [1:0] CYC_ALU_REG = 2'h3;
    localparam logic [1:0] CYC_PACK_SHIFT = 2'h2;
    localparam logic [1:0] CYC_SATQ = 2'h2;
    localparam logic [1:0] CYC_SATD = 2'h3;
    localparam logic [1:0] CYC_PAR = 2'h1;
    localparam logic [1:0] CYC_XTA = 2'h3;
    localparam logic [1:0] CYC_XT = 2'h2;
    localparam logic [1:0] CYC_BF = 2'h2;
    localparam logic [1:0] CYC_MISC = 2'h1;
    localparam logic [1:0] CYC_PSR = 2'h1;

    localparam logic [3:0] AGU_WORD = 4'h1;
    localparam logic [3:0] AGU_BH = 4'h2;
    localparam logic [2:0] LAT_WORD = 3'h3;
    localparam logic [2:0] LAT_WORD_RS = 3'h4;
    localparam logic [2:0] LAT_BH = 3'h4;
    localparam logic [2:0] LAT_BH_RS = 3'h5;
    localparam logic [2:0] LAT_MULTI = 3'h3;
    localparam logic [2:0] FWD_SAVE = 3'h1;

    typedef enum logic [3:0] {
        OP_MOV, OP_ALU, OP_SATQ, OP_SATD, OP_PACK, OP_PAR, OP_XTA,
        OP_XT, OP_BF, OP_MISC, OP_PSR, OP_LOAD, OP_STORE
    } itm_op_e;

    typedef enum logic [1:0] {SH_NONE, SH_CONST, SH_REG} itm_shift_e;
    typedef enum logic [1:0] {SZ_WORD, SZ_BYTE, SZ_HALF} itm_size_e;
    typedef enum logic {AM_SIMPLE, AM_REGSHIFT} itm_amode_e;

    typedef struct packed {
        itm_op_e op;
        itm_shift_e shift;
        itm_size_e size;
        itm_amode_e amode;
        logic sext;
        logic cond;
        logic multi;
        logic aligned;
        logic [4:0] nregs;
        logic [3:0] dst;
        logic dst_vld;
        logic [3:0] src_a;
        logic src_a_vld;
        logic [3:0] src_b;
        logic src_b_vld;
        logic [3:0] src_s;
        logic src_s_vld;
    } itm_instr_s;

    typedef struct packed {
        logic [1:0] exec_cyc;
        logic [3:0] agu_cyc;
        logic [2:0] lat;
        logic fast;
        logic fwd;
        logic pair;
    } itm_disp_s;
endpackage

// [rtl/itm_agu_sched.sv]
// address generation cycle, latency and beat-width decode for memory ops
`timescale 1ns/1ps
module itm_agu_sched
    import itm_pkg::*;
(
    input wire itm_instr_s instr_i,
    output logic [3:0] agu_cyc_o,
    output logic [2:0] lat_o,
    output logic pair_o,
    output logic fast_o
);
    logic mem_op;

    assign mem_op = instr_i.op == OP_LOAD || instr_i.op == OP_STORE;

    always_comb
    begin
        agu_cyc_o = '0;
        lat_o = '0;
        pair_o = 1'b0;
        fast_o = 1'b0;
        if (mem_op)
        begin
            fast_o = instr_i.op == OP_LOAD && !instr_i.cond && !instr_i.sext;
            if (instr_i.multi)
            begin
                // unaligned start spends one single beat, then pairs follow
                if (instr_i.aligned)
                    agu_cyc_o = 4'((instr_i.nregs + 5'h1) >> 1);
                else
                    agu_cyc_o = 4'((instr_i.nregs >> 1) + 5'h1);
                pair_o = instr_i.aligned && instr_i.nregs > 5'h1;
                lat_o = LAT_MULTI;
            end
            else if (instr_i.size == SZ_WORD)
            begin
                agu_cyc_o = AGU_WORD;
                lat_o = instr_i.amode == AM_REGSHIFT ? LAT_WORD_RS : LAT_WORD;
            end
            else
            begin
                agu_cyc_o = AGU_BH;
                lat_o = instr_i.amode == AM_REGSHIFT ? LAT_BH_RS : LAT_BH;
            end
            if (instr_i.op == OP_STORE)
                lat_o = '0;
        end
    end
endmodule

// [rtl/itm_issue_model.sv]
// integer issue timing model: slot, unit occupancy and result scoreboard
`timescale 1ns/1ps
module itm_issue_model
    import itm_pkg::*;
#(
    parameter int NUM_REGS = ITM_NUM_REGS
)
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic ISSUE_VALID_I,
    input wire itm_instr_s ISSUE_INSTR_I,
    output logic ISSUE_READY_O,
    output logic DISP_O,
    output itm_disp_s DISP_INFO_O,
    output logic STALL_O
);
    itm_instr_s slot_r;
    itm_instr_s disp_instr_r;
    logic slot_vld_r;
    logic slot_vld_nxt;
    logic [ITM_SB_W-1:0] sb_cnt_r [NUM_REGS];
    logic [NUM_REGS-1:0] sb_fwd_r;
    logic [1:0] exec_cnt_r;
    logic [ITM_AGU_W-1:0] agu_cnt_r;
    logic [3:0] agu_cyc;
    logic [2:0] lat_mem;
    logic pair_ok;
    logic ld_fast;
    logic [1:0] exec_cyc;
    logic [2:0] prod_lat;
    logic cons_fast;
    logic uses_exec;
    logic unit_ok;
    logic hz_ok;
    logic hz_zero;
    logic fwd_hit;
    logic fwd_used;
    logic dispatch;
    logic capture;
    logic wr_dst;

    function automatic logic [1:0] exec_cycles(itm_op_e op, itm_shift_e sh);
        case (op)
            OP_MOV: return sh == SH_REG ? CYC_MOV_REG : CYC_BASE;
            OP_ALU:
            begin
                case (sh)
                    SH_NONE: return CYC_BASE;
                    SH_CONST: return CYC_ALU_CONST;
                    default: return CYC_ALU_REG;
                endcase
            end
            OP_PACK: return sh == SH_NONE ? CYC_BASE : CYC_PACK_SHIFT;
            OP_SATQ: return CYC_SATQ;
            OP_SATD: return CYC_SATD;
            OP_PAR: return CYC_PAR;
            OP_XTA: return CYC_XTA;
            OP_XT: return CYC_XT;
            OP_BF: return CYC_BF;
            OP_MISC: return CYC_MISC;
            OP_PSR: return CYC_PSR;
            OP_LOAD, OP_STORE: return 2'h0;
            default: return CYC_BASE;
        endcase
    endfunction

    // a source is clear when idle, or one cycle early over the forward path
    function automatic logic src_ok(logic vld, logic [ITM_SB_W-1:0] cnt, logic fw, logic fast);
        return !vld || cnt == '0 || (fast && fw && cnt == FWD_SAVE);
    endfunction

    function automatic logic src_fwd(logic vld, logic [ITM_SB_W-1:0] cnt, logic fw, logic fast);
        return vld && fast && fw && cnt == FWD_SAVE;
    endfunction

    function automatic logic src_idle(logic vld, logic [ITM_SB_W-1:0] cnt);
        return !vld || cnt == '0;
    endfunction

    itm_agu_sched u_agu (
        .instr_i(slot_r),
        .agu_cyc_o(agu_cyc),
        .lat_o(lat_mem),
        .pair_o(pair_ok),
        .fast_o(ld_fast)
    );

    // consumer side of the forward path: unshifted arith, logic or saturate
    assign cons_fast = (slot_r.op == OP_ALU || slot_r.op == OP_SATQ
        || slot_r.op == OP_SATD || slot_r.op == OP_PAR)
        && slot_r.shift == SH_NONE;
    assign uses_exec = slot_r.op != OP_LOAD && slot_r.op != OP_STORE;
    assign exec_cyc = exec_cycles(slot_r.op, slot_r.shift);
    // execute results are taken as ready once the unit finishes
    assign prod_lat = uses_exec ? {1'b0, exec_cyc} : lat_mem;
    assign wr_dst = slot_r.dst_vld && slot_r.op != OP_STORE;
    assign unit_ok = uses_exec ? exec_cnt_r == 2'h0 : agu_cnt_r == '0;

    assign hz_ok = src_ok(slot_r.src_a_vld, sb_cnt_r[slot_r.src_a], sb_fwd_r[slot_r.src_a],
            cons_fast)
        && src_ok(slot_r.src_b_vld, sb_cnt_r[slot_r.src_b], sb_fwd_r[slot_r.src_b], cons_fast)
        && src_ok(slot_r.src_s_vld, sb_cnt_r[slot_r.src_s], sb_fwd_r[slot_r.src_s],
            cons_fast);
    assign fwd_hit = src_fwd(slot_r.src_a_vld, sb_cnt_r[slot_r.src_a],
            sb_fwd_r[slot_r.src_a], cons_fast)
        || src_fwd(slot_r.src_b_vld, sb_cnt_r[slot_r.src_b], sb_fwd_r[slot_r.src_b], cons_fast)
        || src_fwd(slot_r.src_s_vld, sb_cnt_r[slot_r.src_s], sb_fwd_r[slot_r.src_s],
            cons_fast);
    assign hz_zero = src_idle(slot_r.src_a_vld, sb_cnt_r[slot_r.src_a])
        && src_idle(slot_r.src_b_vld, sb_cnt_r[slot_r.src_b])
        && src_idle(slot_r.src_s_vld, sb_cnt_r[slot_r.src_s]);

    assign dispatch = slot_vld_r && hz_ok && unit_ok;
    assign fwd_used = dispatch && fwd_hit;
    assign capture = ISSUE_VALID_I && ISSUE_READY_O;
    assign slot_vld_nxt = capture || (slot_vld_r && !dispatch);

    // single-entry slot: ready is registered, so a new op lands every other edge at best
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            slot_vld_r <= 1'b0;
            slot_r <= '0;
            ISSUE_READY_O <= 1'b1;
        end
        else
        begin
            slot_vld_r <= slot_vld_nxt;
            ISSUE_READY_O <= !slot_vld_nxt;
            if (capture)
                slot_r <= ISSUE_INSTR_I;
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            exec_cnt_r <= 2'h0;
            agu_cnt_r <= '0;
        end
        else
        begin
            if (dispatch && uses_exec)
                exec_cnt_r <= exec_cyc - 2'h1;
            else if (exec_cnt_r != 2'h0)
                exec_cnt_r <= exec_cnt_r - 2'h1;
            if (dispatch && !uses_exec)
                agu_cnt_r <= agu_cyc - 4'h1;
            else if (agu_cnt_r != '0)
                agu_cnt_r <= agu_cnt_r - 4'h1;
        end
    end

    // only the first loaded register is tracked; later ones trail it
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            sb_fwd_r <= '0;
            for (int i = 0; i < NUM_REGS; i++)
                sb_cnt_r[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
                if (dispatch && wr_dst && slot_r.dst == 4'(i))
                begin
                    sb_cnt_r[i] <= prod_lat - 3'h1;
                    sb_fwd_r[i] <= !uses_exec && ld_fast;
                end
                else if (sb_cnt_r[i] != '0)
                    sb_cnt_r[i] <= sb_cnt_r[i] - 3'h1;
            end
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            DISP_O <= 1'b0;
            STALL_O <= 1'b0;
            DISP_INFO_O <= '0;
            disp_instr_r <= '0;
        end
        else
        begin
            DISP_O <= dispatch;
            STALL_O <= slot_vld_r && !dispatch;
            if (dispatch)
            begin
                disp_instr_r <= slot_r;
                DISP_INFO_O.exec_cyc <= exec_cyc;
                DISP_INFO_O.agu_cyc <= agu_cyc;
                DISP_INFO_O.lat <= prod_lat;
                DISP_INFO_O.fast <= !uses_exec && ld_fast;
                DISP_INFO_O.fwd <= fwd_used;
                DISP_INFO_O.pair <= pair_ok;
            end
        end
    end

    function automatic logic disp_is(itm_op_e o);
        return DISP_O && disp_instr_r.op == o;
    endfunction

    function automatic logic disp_ld(itm_size_e s, itm_amode_e m);
        return disp_is(OP_LOAD) && !disp_instr_r.multi && (disp_instr_r.size == SZ_WORD)
            == (s == SZ_WORD) && disp_instr_r.amode == m;
    endfunction

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    sequence exec_idle_s;
        !(DISP_O && disp_instr_r.op != OP_LOAD && disp_instr_r.op != OP_STORE);
    endsequence

    sequence reg_shift_alu_s;
        disp_is(OP_ALU) && disp_instr_r.shift == SH_REG;
    endsequence

    shift_forms_a: assert property (
        disp_is(OP_ALU) && disp_instr_r.shift == SH_NONE |-> DISP_INFO_O.exec_cyc == CYC_BASE)
        else $error("unshifted alu count wrong");
    move_count_a: assert property (
        disp_is(OP_MOV) |-> DISP_INFO_O.exec_cyc
            == (disp_instr_r.shift == SH_REG ? CYC_MOV_REG : CYC_BASE))
        else $error("move count wrong");
    alu_count_a: assert property (
        disp_is(OP_ALU) && disp_instr_r.shift != SH_NONE |-> DISP_INFO_O.exec_cyc
            == (disp_instr_r.shift == SH_CONST ? CYC_ALU_CONST : CYC_ALU_REG))
        else $error("shifted alu count wrong");
    sat_count_a: assert property (
        disp_is(OP_SATQ) |-> DISP_INFO_O.exec_cyc == CYC_SATQ)
        else $error("saturating count wrong");
    dsat_count_a: assert property (
        disp_is(OP_SATD) |-> DISP_INFO_O.exec_cyc == CYC_SATD)
        else $error("doubling saturate count wrong");
    par_count_a: assert property (
        disp_is(OP_PAR) |-> DISP_INFO_O.exec_cyc == CYC_PAR)
        else $error("parallel op count wrong");
    xta_count_a: assert property (
        disp_is(OP_XTA) |-> DISP_INFO_O.exec_cyc == CYC_XTA)
        else $error("extend-add count wrong");
    xt_count_a: assert property (
        disp_is(OP_XT) |-> DISP_INFO_O.exec_cyc == CYC_XT)
        else $error("extend count wrong");
    bf_count_a: assert property (
        disp_is(OP_BF) |-> DISP_INFO_O.exec_cyc == CYC_BF)
        else $error("bitfield count wrong");
    misc_count_a: assert property (
        disp_is(OP_MISC) |-> DISP_INFO_O.exec_cyc == CYC_MISC && DISP_INFO_O.lat == 3'h1)
        else $error("single cycle op count wrong");
    psr_count_a: assert property (
        disp_is(OP_PSR) |-> DISP_INFO_O.exec_cyc == CYC_PSR)
        else $error("status write count wrong");
    fwd_save_a: assert property (
        fwd_used |-> !hz_zero ##1 DISP_O && DISP_INFO_O.fwd)
        else $error("forward not exactly one cycle early");
    fwd_cond_a: assert property (
        DISP_O && DISP_INFO_O.fwd |-> disp_instr_r.shift == SH_NONE
            && disp_instr_r.op inside {OP_ALU, OP_SATQ, OP_SATD, OP_PAR})
        else $error("forward used by ineligible consumer");
    first_reg_a: assert property (
        disp_is(OP_LOAD) && disp_instr_r.dst_vld
            |-> sb_cnt_r[disp_instr_r.dst] == DISP_INFO_O.lat - 3'h1)
        else $error("first register latency not tracked");
    ld_word_a: assert property (
        disp_ld(SZ_WORD, AM_SIMPLE) |-> DISP_INFO_O.agu_cyc == AGU_WORD
            && DISP_INFO_O.lat == LAT_WORD)
        else $error("word load timing wrong");
    ld_word_rs_a: assert property (
        disp_ld(SZ_WORD, AM_REGSHIFT) |-> DISP_INFO_O.agu_cyc == AGU_WORD
            && DISP_INFO_O.lat == LAT_WORD_RS)
        else $error("shifted word load timing wrong");
    ld_bh_a: assert property (
        disp_ld(SZ_BYTE, AM_SIMPLE) |-> DISP_INFO_O.agu_cyc == AGU_BH
            && DISP_INFO_O.lat == LAT_BH)
        else $error("byte load timing wrong");
    ld_bh_rs_a: assert property (
        disp_ld(SZ_BYTE, AM_REGSHIFT) |-> DISP_INFO_O.agu_cyc == AGU_BH
            && DISP_INFO_O.lat == LAT_BH_RS)
        else $error("shifted byte load timing wrong");
    pair_align_a: assert property (
        DISP_O && DISP_INFO_O.pair |-> disp_instr_r.aligned && disp_instr_r.multi)
        else $error("64-bit beat on unaligned address");
    multi_cyc_a: assert property (
        DISP_O && disp_instr_r.multi && disp_instr_r.nregs == 5'h4
            |-> DISP_INFO_O.agu_cyc == (disp_instr_r.aligned ? 4'h2 : 4'h3))
        else $error("multi transfer cycle count wrong");
    exec_hold_a: assert property (
        reg_shift_alu_s |=> exec_idle_s [*2])
        else $error("execute unit reissued early");
    use_wait_a: assert property (
        dispatch && !fwd_used |-> hz_zero)
        else $error("consumer issued before producer latency");
endmodule

// [tb/itm_issue_model_test.sv]
// self-checking bench for the integer issue timing model
`timescale 1ns/1ps
module itm_issue_model_test;
    import itm_pkg::*;
    logic CLK_I;
    logic SYS_RST_I;
    logic ISSUE_VALID_I;
    itm_instr_s ISSUE_INSTR_I;
    logic ISSUE_READY_O;
    logic DISP_O;
    itm_disp_s DISP_INFO_O;
    logic STALL_O;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    int stalls = 0;
    int dt[$];
    itm_disp_s di[$];

    itm_issue_model #(.NUM_REGS(16)) dut (
        .CLK_I(CLK_I),
        .SYS_RST_I(SYS_RST_I),
        .ISSUE_VALID_I(ISSUE_VALID_I),
        .ISSUE_INSTR_I(ISSUE_INSTR_I),
        .ISSUE_READY_O(ISSUE_READY_O),
        .DISP_O(DISP_O),
        .DISP_INFO_O(DISP_INFO_O),
        .STALL_O(STALL_O)
    );

    initial
    begin
        CLK_I = 1'b0;
        forever #12.5 CLK_I = ~CLK_I;
    end

    always @(posedge CLK_I) cyc <= cyc + 1;

    // dispatch times and infos logged on the settled half of the cycle
    always @(negedge CLK_I)
    begin
        if (DISP_O === 1'b1)
        begin
            dt.push_back(cyc);
            di.push_back(DISP_INFO_O);
        end
        if (STALL_O === 1'b1)
            stalls++;
    end

    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input int exp);
        n_compared++;
        if (seen !== 16'(exp))
        begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic hang(input string what);
        miscompares++;
        $display("MISMATCH %s expected done seen timeout", what);
        results();
    endtask

    function automatic itm_instr_s mk(input itm_op_e op, input itm_shift_e sh,
        input logic [3:0] dst, input logic [3:0] src);
        itm_instr_s r;
        r = '0;
        r.op = op;
        r.shift = sh;
        r.dst = dst;
        r.dst_vld = (op != OP_STORE);
        r.src_a = src;
        r.src_a_vld = (src != 4'h0);
        r.nregs = 5'h01;
        r.aligned = 1'b1;
        return r;
    endfunction

    task automatic clear();
        dt.delete();
        di.delete();
        stalls = 0;
    endtask

    // entered on a falling edge; leaves valid up so back-to-back offers never glitch it
    task automatic offer(input itm_instr_s ins);
        int n;
        ISSUE_VALID_I = 1'b1;
        ISSUE_INSTR_I = ins;
        n = 0;
        while (ISSUE_READY_O !== 1'b1)
        begin
            @(negedge CLK_I);
            n++;
            if (n > 60)
                hang("issue take");
        end
        @(negedge CLK_I);
    endtask

    task automatic drain(input int cnt);
        int n;
        ISSUE_VALID_I = 1'b0;
        n = 0;
        while (dt.size() < cnt)
        begin
            @(posedge CLK_I);
            n++;
            if (n > 60)
                hang("dispatch");
        end
        repeat (3) @(negedge CLK_I);
    endtask

    task automatic reset_vals();
        check("ready in reset", ISSUE_READY_O, 1);
        check("disp in reset", DISP_O, 0);
        check("stall in reset", STALL_O, 0);
        check("info in reset", DISP_INFO_O, 0);
    endtask

    task automatic exec_table();
        itm_op_e op[16] = '{OP_MOV, OP_MOV, OP_MOV, OP_ALU, OP_ALU, OP_ALU, OP_SATQ, OP_SATD,
            OP_PACK, OP_PACK, OP_PAR, OP_XTA, OP_XT, OP_BF, OP_MISC, OP_PSR};
        itm_shift_e sh[16] = '{SH_NONE, SH_CONST, SH_REG, SH_NONE, SH_CONST, SH_REG, SH_NONE,
            SH_NONE, SH_NONE, SH_CONST, SH_NONE, SH_NONE, SH_NONE, SH_NONE, SH_NONE, SH_NONE};
        int cy[16] = '{1, 1, 2, 1, 2, 3, 2, 3, 1, 2, 1, 3, 2, 2, 1, 1};
        for (int i = 0; i < 16; i++)
        begin
            clear();
            offer(mk(op[i], sh[i], 4'h1, 4'h0));
            offer(mk(OP_ALU, SH_NONE, 4'h2, 4'h0));
            drain(2);
            check("exec cycles", di[0].exec_cyc, cy[i]);
            check("exec agu", di[0].agu_cyc, 0);
            check("exec spacing", 16'(dt[1] - dt[0]), cy[i] > 2 ? cy[i] : 2);
        end
    endtask

    task automatic load_table();
        itm_size_e sz[8] = '{SZ_WORD, SZ_WORD, SZ_WORD, SZ_WORD, SZ_BYTE, SZ_HALF, SZ_BYTE,
            SZ_HALF};
        itm_amode_e am[8] = '{AM_SIMPLE, AM_SIMPLE, AM_SIMPLE, AM_REGSHIFT, AM_SIMPLE,
            AM_SIMPLE, AM_REGSHIFT, AM_REGSHIFT};
        logic sx[8] = '{0, 0, 0, 0, 0, 1, 0, 0};
        logic cd[8] = '{0, 0, 1, 0, 0, 0, 0, 0};
        itm_op_e cop[8] = '{OP_ALU, OP_ALU, OP_ALU, OP_SATQ, OP_PAR, OP_ALU, OP_SATD, OP_MOV};
        itm_shift_e csh[8] = '{SH_NONE, SH_CONST, SH_NONE, SH_NONE, SH_NONE, SH_NONE, SH_NONE,
            SH_NONE};
        int ag[8] = '{1, 1, 1, 1, 2, 2, 2, 2};
        int lt[8] = '{3, 3, 3, 4, 4, 4, 5, 5};
        int fw[8] = '{1, 0, 0, 1, 1, 0, 1, 0};
        itm_instr_s ld;
        for (int i = 0; i < 8; i++)
        begin
            ld = mk(OP_LOAD, SH_NONE, 4'h3, 4'h4);
            ld.size = sz[i];
            ld.amode = am[i];
            ld.sext = sx[i];
            ld.cond = cd[i];
            clear();
            offer(ld);
            offer(mk(cop[i], csh[i], 4'h5, 4'h3));
            drain(2);
            check("load agu", di[0].agu_cyc, ag[i]);
            check("load latency", di[0].lat, lt[i]);
            check("load exec", di[0].exec_cyc, 0);
            check("load fast", di[0].fast, !cd[i] && !sx[i]);
            check("load pair", di[0].pair, 0);
            check("use forward", di[1].fwd, fw[i]);
            check("use spacing", 16'(dt[1] - dt[0]), lt[i] - fw[i]);
            check("use stalls", 16'(stalls), lt[i] - fw[i] - 2);
        end
    endtask

    // next memory op must wait out the address generator, whatever its registers
    task automatic multi_table();
        itm_op_e op[7] = '{OP_LOAD, OP_LOAD, OP_STORE, OP_LOAD, OP_LOAD, OP_LOAD, OP_STORE};
        int nr[7] = '{16, 16, 16, 2, 1, 4, 4};
        logic al[7] = '{1, 0, 0, 1, 0, 1, 0};
        int ag[7] = '{8, 9, 9, 1, 1, 2, 3};
        int pr[7] = '{1, 0, 0, 1, 0, 1, 0};
        itm_instr_s m;
        for (int i = 0; i < 7; i++)
        begin
            m = mk(op[i], SH_NONE, 4'h6, 4'h0);
            m.multi = 1'b1;
            m.nregs = 5'(nr[i]);
            m.aligned = al[i];
            clear();
            offer(m);
            offer(mk(OP_LOAD, SH_NONE, 4'h7, 4'h0));
            drain(2);
            check("multi agu", di[0].agu_cyc, ag[i]);
            check("multi pair", di[0].pair, pr[i]);
            check("multi latency", di[0].lat, op[i] == OP_LOAD ? 3 : 0);
            check("multi spacing", 16'(dt[1] - dt[0]), ag[i] > 2 ? ag[i] : 2);
        end
    endtask

    // reset after a slow load has dispatched must forget its pending result
    task automatic reset_mid();
        itm_instr_s ld;
        ld = mk(OP_LOAD, SH_NONE, 4'h8, 4'h0);
        ld.size = SZ_BYTE;
        ld.amode = AM_REGSHIFT;
        clear();
        offer(ld);
        ISSUE_VALID_I = 1'b0;
        @(negedge CLK_I);
        SYS_RST_I = 1'b1;
        @(negedge CLK_I);
        reset_vals();
        SYS_RST_I = 1'b0;
        clear();
        offer(mk(OP_ALU, SH_NONE, 4'h9, 4'h8));
        drain(1);
        check("stalls after reset", 16'(stalls), 0);
    endtask

    initial
    begin
        SYS_RST_I = 1'b1;
        ISSUE_VALID_I = 1'b0;
        ISSUE_INSTR_I = '0;
        repeat (6) @(negedge CLK_I);
        reset_vals();
        SYS_RST_I = 1'b0;
        @(negedge CLK_I);
        exec_table();
        load_table();
        multi_table();
        reset_mid();
        results();
    end
endmodule
